// ---- logic/alarm_regs_pkg.sv ----
// alarm match register set: offsets, fields, reset values, mask codes
// shared by the alarm register block and its per-alarm match unit
package alarm_regs_pkg;

  // byte offsets on the register port
  localparam logic [7:0] ALM0_MIN_OFS   = 8'h0b;
  localparam logic [7:0] ALM0_HOUR_OFS  = 8'h0c;
  localparam logic [7:0] ALM0_DAY_OF_WEEK_VALUE_OFS = 8'h0d;
  localparam logic [7:0] ALM1_MIN_OFS   = 8'h12;
  localparam logic [7:0] ALM1_HOUR_OFS  = 8'h13;
  localparam logic [7:0] ALM1_DAY_OF_WEEK_VALUE_OFS = 8'h14;

  // reset values
  localparam logic [6:0] MIN_RESET   = 7'h00;
  localparam logic [5:0] HOUR_RESET  = 6'h00;
  localparam logic [2:0] DAY_OF_WEEK_VALUE_RESET = 3'h1;
  localparam logic [2:0] MASK_RESET  = 3'h0;

  // field positions in the weekday and control register
  localparam int POL_BIT      = 7;
  localparam int MASK_MSB     = 6;
  localparam int MASK_LSB     = 4;
  localparam int FLAG_BIT     = 3;
  localparam int DAY_OF_WEEK_VALUE_MSB    = 2;
  // hour register: format bit position
  localparam int HOUR_FMT_BIT = 6;

  // match select codes
  typedef enum logic [2:0] {
    MATCH_SEC   = 3'b000,
    MATCH_MIN   = 3'b001,
    MATCH_HOUR  = 3'b010,
    MATCH_DAY_OF_WEEK_VALUE = 3'b011,
    MATCH_DATE  = 3'b100,
    MATCH_RSV5  = 3'b101,
    MATCH_RSV6  = 3'b110,
    MATCH_ALL   = 3'b111
  } match_sel_t;

endpackage

// ---- logic/alarm_match_unit.sv ----
// one alarm: compare against current time and hold its match flag
// assumes time inputs are BCD and synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module alarm_match_unit
  import alarm_regs_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // stored compare values
  input  wire logic [2:0] matchSel,
  input  wire logic [6:0] cmpSec,
  input  wire logic [6:0] cmpMin,
  input  wire logic [5:0] cmpHour,
  input  wire logic [2:0] cmpWkday,
  input  wire logic [5:0] cmpDate,
  input  wire logic [4:0] cmpMonth,
  // current time
  input  wire logic [6:0] curSec,
  input  wire logic [6:0] curMin,
  input  wire logic [5:0] curHour,
  input  wire logic [2:0] curWkday,
  input  wire logic [5:0] curDate,
  input  wire logic [4:0] curMonth,
  // flag control
  input  wire logic       flagClear,
  output logic            flag
);

  logic matchNow;
  logic flag_reg;
  logic flag_next;
  logic secEq;
  logic minEq;
  logic hourEq;
  logic dayEq;
  logic dateEq;
  logic monEq;

  // field equality; hour compare covers meridiem or tens bits alike
  always_comb begin
    secEq  = (cmpSec == curSec);
    minEq  = (cmpMin == curMin);
    hourEq = (cmpHour == curHour);
    dayEq  = (cmpWkday == curWkday);
    dateEq = (cmpDate == curDate);
    monEq  = (cmpMonth == curMonth);
  end

  // selected match condition; reserved codes never match
  always_comb begin
    unique case (match_sel_t'(matchSel))
      MATCH_SEC:   matchNow = secEq;
      MATCH_MIN:   matchNow = minEq;
      MATCH_HOUR:  matchNow = hourEq;
      MATCH_DAY_OF_WEEK_VALUE: matchNow = dayEq;
      MATCH_DATE:  matchNow = dateEq;
      MATCH_ALL:   matchNow = secEq & minEq & hourEq & dayEq & dateEq
                              & monEq;
      default:     matchNow = 1'b0;
    endcase
  end

  // set beats clear, so a lasting match re-sets the flag at once
  always_comb begin
    flag_next = flag_reg;
    if (flagClear) begin
      flag_next = 1'b0;
    end
    if (matchNow) begin
      flag_next = 1'b1;
    end
  end

  // flag register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule
`default_nettype wire

// ---- logic/rtc_alarm_match_registers.sv ----
// alarm compare registers for two alarms and the alarm output pin
// assumes a decoded byte register port from the serial bus front end
// assumes current time is bcd and synchronous to ref_clk
// one polarity bit is shared by both alarms
// How it works
// - minute compare: tens 6-4, ones 3-0
// - bit 7 of minute/hour reads zero
// - 12-hour: bit 5 set means afternoon
// - polarity bit sets asserted pin level
// - mask field picks compared time field
// - match sets flag; only software clears
// - weekday compare value in bits 2-0
// - code 111 needs every field matching
// - flag unwritable as one; write clears
// - lasting match sets cleared flag again
// - alarms enabled, square wave off: alarm output
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_match_registers
  import alarm_regs_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  // current time from timekeeping
  input  wire logic [6:0]  curSec,
  input  wire logic [6:0]  curMin,
  input  wire logic [5:0]  curHour,
  input  wire logic [2:0]  curWkday,
  input  wire logic [5:0]  curDate,
  input  wire logic [4:0]  curMonth,
  input  wire logic        hourFormat12,
  // other alarm compare values, per alarm
  input  wire logic [13:0] alarmSecCmp,
  input  wire logic [11:0] alarmDateCmp,
  input  wire logic [9:0]  alarmMonthCmp,
  // output configuration
  input  wire logic [1:0]  alarmEnable,
  input  wire logic        squareWaveEnable,
  input  wire logic        squareWaveLevel,
  input  wire logic        generalOutLevel,
  // multi-function pin, open drain
  input  wire logic        multiFunctionPinIn,
  output logic             multiFunctionPinOut,
  output logic             multiFunctionPinOe,
  // flags
  output logic      [1:0]  alarmMatchFlag
);

  logic [6:0] minCmp_reg   [2];
  logic [6:0] minCmp_next  [2];
  logic [5:0] hourCmp_reg  [2];
  logic [5:0] hourCmp_next [2];
  logic [2:0] maskSel_reg  [2];
  logic [2:0] maskSel_next [2];
  logic [2:0] day_of_week_value_reg    [2];
  logic [2:0] day_of_week_value_next   [2];
  logic       pol_reg;
  logic       pol_next;
  logic [1:0] flagRaw;
  logic [1:0] flagClr;
  logic [1:0] flag_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       pinLow_reg;
  logic       pinLow_next;
  logic       alarmLevel;
  logic [1:0] minWr;
  logic [1:0] hourWr;
  logic [1:0] wkWr;
  logic [7:0] hourByte     [2];
  logic [7:0] wkByte       [2];
  logic [1:0] flag_next;

  // per-alarm registers and match units
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    localparam logic [7:0] MIN_OFS  = (i == 0) ? ALM0_MIN_OFS
                                               : ALM1_MIN_OFS;
    localparam logic [7:0] HOUR_OFS = (i == 0) ? ALM0_HOUR_OFS
                                               : ALM1_HOUR_OFS;
    localparam logic [7:0] WK_OFS   = (i == 0) ? ALM0_DAY_OF_WEEK_VALUE_OFS
                                               : ALM1_DAY_OF_WEEK_VALUE_OFS;

    // write strobes for this alarm's three registers
    assign minWr[i]  = regWrite && (regAddr == MIN_OFS);
    assign hourWr[i] = regWrite && (regAddr == HOUR_OFS);
    assign wkWr[i]   = regWrite && (regAddr == WK_OFS);

    // next values on writes; bit 7 and format bit are dropped
    always_comb begin
      minCmp_next[i]  = minCmp_reg[i];
      hourCmp_next[i] = hourCmp_reg[i];
      maskSel_next[i] = maskSel_reg[i];
      day_of_week_value_next[i]   = day_of_week_value_reg[i];
      flagClr[i]      = 1'b0;
      if (minWr[i]) begin
        minCmp_next[i] = regWdata[6:0];
      end
      if (hourWr[i]) begin
        hourCmp_next[i] = regWdata[5:0];
      end
      if (wkWr[i]) begin
        maskSel_next[i] = regWdata[MASK_MSB:MASK_LSB];
        day_of_week_value_next[i]   = regWdata[DAY_OF_WEEK_VALUE_MSB:0];
        flagClr[i]      = 1'b1;
      end
    end

    // register stage
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        minCmp_reg[i]  <= MIN_RESET;
        hourCmp_reg[i] <= HOUR_RESET;
        maskSel_reg[i] <= MASK_RESET;
        day_of_week_value_reg[i]   <= DAY_OF_WEEK_VALUE_RESET;
      end else begin
        minCmp_reg[i]  <= minCmp_next[i];
        hourCmp_reg[i] <= hourCmp_next[i];
        maskSel_reg[i] <= maskSel_next[i];
        day_of_week_value_reg[i]   <= day_of_week_value_next[i];
      end
    end

    // readback bytes, fields at their named positions; hour bit 7 stays zero, weekday bit 7 is polarity
    always_comb begin
      hourByte[i]                  = {2'b00, hourCmp_reg[i]};
      hourByte[i][HOUR_FMT_BIT]    = hourFormat12;
      wkByte[i]                    = 8'h00;
      wkByte[i][POL_BIT]           = pol_reg;
      wkByte[i][MASK_MSB:MASK_LSB] = maskSel_reg[i];
      wkByte[i][FLAG_BIT]          = flagRaw[i];
      wkByte[i][DAY_OF_WEEK_VALUE_MSB:0]       = day_of_week_value_reg[i];
    end

    alarm_match_unit u_match (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .matchSel  (maskSel_reg[i]),
      .cmpSec    (alarmSecCmp[7*i +: 7]),
      .cmpMin    (minCmp_reg[i]),
      .cmpHour   (hourCmp_reg[i]),
      .cmpWkday  (day_of_week_value_reg[i]),
      .cmpDate   (alarmDateCmp[6*i +: 6]),
      .cmpMonth  (alarmMonthCmp[5*i +: 5]),
      .curSec    (curSec),
      .curMin    (curMin),
      .curHour   (curHour),
      .curWkday  (curWkday),
      .curDate   (curDate),
      .curMonth  (curMonth),
      .flagClear (flagClr[i]),
      .flag      (flagRaw[i])
    );
  end

  // shared polarity bit, written through either weekday register
  always_comb begin
    pol_next = pol_reg;
    if (|wkWr) begin
      pol_next = regWdata[POL_BIT];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (regAddr)
      ALM0_MIN_OFS:   rdata_next = {1'b0, minCmp_reg[0]};
      ALM1_MIN_OFS:   rdata_next = {1'b0, minCmp_reg[1]};
      ALM0_HOUR_OFS:  rdata_next = hourByte[0];
      ALM1_HOUR_OFS:  rdata_next = hourByte[1];
      ALM0_DAY_OF_WEEK_VALUE_OFS: rdata_next = wkByte[0];
      ALM1_DAY_OF_WEEK_VALUE_OFS: rdata_next = wkByte[1];
      default:        rdata_next = 8'h00;
    endcase
  end

  // pin mode select; low level is driven, high is released
  always_comb begin
    alarmLevel = |(flagRaw & alarmEnable);
    if (squareWaveEnable) begin
      pinLow_next = ~squareWaveLevel;
    end else if (|alarmEnable) begin
      pinLow_next = pol_reg ? ~alarmLevel : alarmLevel;
    end else begin
      pinLow_next = ~generalOutLevel;
    end
  end

  // flag port copy, one cycle behind the live flags
  always_comb begin
    flag_next = flagRaw;
  end

  // shared state and outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pol_reg    <= 1'b0;
      rdata_reg  <= 8'h00;
      pinLow_reg <= 1'b0;
      flag_reg   <= 2'b00;
    end else begin
      pol_reg    <= pol_next;
      rdata_reg  <= rdata_next;
      pinLow_reg <= pinLow_next;
      flag_reg   <= flag_next;
    end
  end

  assign regRdata            = rdata_reg;
  assign multiFunctionPinOe  = pinLow_reg;
  assign multiFunctionPinOut = 1'b0;
  assign alarmMatchFlag      = flag_reg;

endmodule
`default_nettype wire

// ---- tb/rtc_alarm_props.sv ----
// checker: register readback and pin relations of the alarm block
// bound to the block; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_props (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // configuration and outputs
  input wire logic       hourFormat12,
  input wire logic [1:0] alarmEnable,
  input wire logic       squareWaveEnable,
  input wire logic       squareWaveLevel,
  input wire logic       generalOutLevel,
  input wire logic       multiFunctionPinOe,
  input wire logic [1:0] alarmMatchFlag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // readback of stored compare values
  rd7_zero_a: assert property (
    !$past(rst) && $past(regAddr) inside {8'h0b, 8'h0c, 8'h12, 8'h13}
    |-> !regRdata[7]) else $error("top bit of compare set");
  fmt_mirror_a: assert property (
    !$past(rst) && $past(regAddr) inside {8'h0c, 8'h13}
    |-> regRdata[6] == $past(hourFormat12)) else $error("format bit");
  min_store_a: assert property (
    regWrite && regAddr == 8'h0b ##1 regAddr == 8'h0b && !regWrite
    |=> regRdata == ($past(regWdata, 2) & 8'h7f)) else $error("minute");
  hour_store_a: assert property (
    regWrite && regAddr == 8'h13 ##1 regAddr == 8'h13 && !regWrite
    |=> regRdata == (($past(regWdata, 2) & 8'h3f)
    | {1'b0, $past(hourFormat12), 6'h00})) else $error("hour");
  wk_store_a: assert property (
    regWrite && regAddr == 8'h0d ##1 regAddr == 8'h0d && !regWrite
    |=> (regRdata & 8'hf7) == ($past(regWdata, 2) & 8'hf7))
    else $error("weekday");
  // flag falls only after a weekday write
  flag_clear_a: assert property (
    $fell(alarmMatchFlag[0]) |-> $past(regWrite && regAddr == 8'h0d, 2))
    else $error("flag fell without write");
  // pin modes
  sqw_pin_a: assert property (
    !$past(rst) && $past(squareWaveEnable)
    |-> multiFunctionPinOe == !$past(squareWaveLevel)) else $error("sqw");
  gpo_pin_a: assert property (
    !$past(rst) && $past(!squareWaveEnable && alarmEnable == 2'b00)
    |-> multiFunctionPinOe == !$past(generalOutLevel)) else $error("gpo");
endmodule
bind rtc_alarm_match_registers rtc_alarm_props i_props (.*);
`default_nettype wire

// ---- tb/host_model.sv ----
// host side: single byte writes and reads on the register port
// callers load bcd digits, weekday 1..7 and no reserved mask codes
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic      [7:0] regAddr = 8'h00,
  output logic            regWrite = 1'b0,
  output logic      [7:0] regWdata = 8'h00,
  input  wire logic [7:0] regRdata
);
  // write held until the taking edge; weekday write clears the flag
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWrite <= 1'b1;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~d; // no stale data left on the bus
  endtask
  // read: offset presented, data one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    @(posedge ref_clk);
    #1 d = regRdata;
  endtask
endmodule
`default_nettype wire

// ---- tb/rtc_alarm_match_registers_bench.sv ----
// bench: registers, match codes, flag and pin modes of the alarm block
// host model drives the register port; pin has a pull-up
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_match_registers_bench;
  import alarm_regs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  wire  [7:0]  regAddr, regWdata, regRdata;
  wire         regWrite, multiFunctionPinOut, multiFunctionPinOe;
  wire  [1:0]  alarmMatchFlag;
  logic [7:0]  rdv;
  logic [6:0]  curSec = 7'h00, curMin = 7'h30;
  logic [5:0]  curHour = 6'h25, curDate = 6'h01;
  logic [2:0]  curWkday = 3'h1;
  logic [4:0]  curMonth = 5'h01;
  logic        hourFormat12 = 1'b1, squareWaveEnable = 1'b0;
  logic        squareWaveLevel = 1'b0, generalOutLevel = 1'b0;
  logic [13:0] alarmSecCmp = 14'h0000;
  logic [11:0] alarmDateCmp = 12'h041;
  logic [9:0]  alarmMonthCmp = 10'h021;
  logic [1:0]  alarmEnable = 2'b00;
  int          err_total = 0, checks = 0;
  // pull-up wire level
  wire multiFunctionPinIn = multiFunctionPinOe ? multiFunctionPinOut : 1'b1;
  rtc_alarm_match_registers i_dut (.*);
  host_model i_host (.*);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, m, exp);
    i_host.rd(a, rdv);
    chk(exp, rdv & m);
  endtask
  // move one time field off or back onto its compare value
  task automatic bump(input int c, input logic off);
    @(posedge ref_clk);
    case (c)
      0: curSec <= off ? 7'h17 : 7'h00;
      1: curMin <= off ? 7'h42 : 7'h30;
      2: curHour <= off ? 6'h05 : 6'h25;
      3: curWkday <= off ? 3'h6 : 3'h1;
      4: curDate <= off ? 6'h13 : 6'h01;
      default: curMonth <= off ? 5'h12 : 5'h01;
    endcase
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic pin(input logic e);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({7'h00, e}, {7'h00, multiFunctionPinOe});
    chk({7'h00, !e}, {7'h00, multiFunctionPinIn});
  endtask
  task automatic t_regs;
    rchk(8'h0b, 8'hff, 8'h00);
    rchk(8'h0c, 8'hff, 8'h40);
    rchk(8'h14, 8'hf7, 8'h01);
    i_host.wr(8'h0b, 8'hb0);
    rchk(8'h0b, 8'hff, 8'h30);
    i_host.wr(8'h13, 8'hd2);
    rchk(8'h13, 8'hff, 8'h52);
    @(posedge ref_clk) hourFormat12 <= 1'b0;
    rchk(8'h13, 8'hff, 8'h12);
    @(posedge ref_clk) hourFormat12 <= 1'b1;
    i_host.wr(8'h0c, 8'h25);
    i_host.wr(8'h20, 8'h55);
    rchk(8'h20, 8'hff, 8'h00);
    $display("registers done");
  endtask
  task automatic t_match;
    for (int c = 0; c < 6; c++) begin
      bump(c, 1'b1);
      // old selection may still match at the first write; write twice
      repeat (2) i_host.wr(8'h0d, {1'b0, (c > 4) ? 3'b111 : 3'(c), 4'h9});
      rchk(8'h0d, 8'h08, 8'h00);
      chk(8'h02, {6'h00, alarmMatchFlag});
      bump(c, 1'b0);
      rchk(8'h0d, 8'h08, 8'h08);
      chk(8'h03, {6'h00, alarmMatchFlag});
    end
    i_host.wr(8'h0d, 8'h21);
    rchk(8'h0d, 8'h08, 8'h08);
    @(posedge ref_clk) curHour <= 6'h05;
    i_host.wr(8'h0d, 8'h21);
    rchk(8'h0d, 8'h08, 8'h00);
    $display("match done");
  endtask
  task automatic t_pin;
    @(posedge ref_clk) alarmEnable <= 2'b01;
    pin(1'b0);
    @(posedge ref_clk) curHour <= 6'h25;
    pin(1'b1);
    i_host.wr(8'h0d, 8'ha1);
    pin(1'b0);
    @(posedge ref_clk) squareWaveEnable <= 1'b1;
    pin(1'b1);
    @(posedge ref_clk) {squareWaveEnable, alarmEnable} <= 3'b000;
    pin(1'b1);
    @(posedge ref_clk) generalOutLevel <= 1'b1;
    pin(1'b0);
    $display("pin done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_match;
    t_pin;
    conclude;
  end
  // watchdog, well beyond the run length
  initial begin
    #1000000;
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
